// [inc/flash_seq_pkg.sv]
package flash_seq_pkg;

	// ****************************************
	// Control register layout and patterns
	// ****************************************

	// Bus address of the control register, and its reset value.
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [7:0] CTRL_RESET   = 8'h00;

	// Bit positions inside the control register.
	localparam int BIT_ENABLE  = 0;
	localparam int BIT_ERASE   = 1;
	localparam int BIT_WRITE   = 2;
	localparam int BIT_LOCK    = 3;
	localparam int BIT_REEN    = 4;
	localparam int BIT_BUSY    = 6;
	localparam int BIT_IRQ_EN  = 7;

	// Accepted patterns of the lower five control bits.
	localparam logic [4:0] PAT_REEN  = 5'h11;
	localparam logic [4:0] PAT_LOCK  = 5'h09;
	localparam logic [4:0] PAT_WRITE = 5'h05;
	localparam logic [4:0] PAT_ERASE = 5'h03;
	localparam logic [4:0] PAT_LOAD  = 5'h01;

	// ****************************************
	// Timing windows in core clock cycles
	// ****************************************

	// Cycles after arming in which a store is taken.
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	// Cycles after arming in which a lock or fuse read is taken.
	localparam logic [2:0] READ_WINDOW  = 3'h3;

	// ****************************************
	// Types
	// ****************************************

	// Operation state, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ERASE = 4'b0010,
		ST_WRITE = 4'b0100,
		ST_LOCK  = 4'b1000
	} op_state_t;

	// Command handed to the flash array.
	typedef struct packed {
		logic        start;
		logic        erase;
		logic        write;
		logic        lock;
		logic [15:0] page;
		logic [7:0]  lock_data;
	} flash_cmd_t;

endpackage

// [tb/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
	input  wire logic                      clk_in,
	input  wire logic                      rstn_in,
	input  wire flash_seq_pkg::flash_cmd_t cmd_in,
	input  wire logic [3:0]                delay_in,
	output logic                           done_out
);
	import flash_seq_pkg::*;

	logic [3:0] count;
	logic       busy;

	// Behaves as the array: each start runs for delay_in + 1 cycles, then done.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy     <= 1'b0;
			count    <= 4'h0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (cmd_in.start) begin
				busy  <= 1'b1;
				count <= delay_in;
			end else if (busy && count == 4'h0) begin
				busy     <= 1'b0;
				done_out <= 1'b1;
			end else if (busy) begin
				count <= count - 4'h1;
			end
		end
	end
endmodule // flash_array_model

// [tb/flash_self_program_sequencer_tb.sv]
`timescale 1ns/1ps
module flash_self_program_sequencer_tb;
	import flash_seq_pkg::*;

	logic        clk_in, rstn_in, cyc, stb, we, ack, store, load, done;
	logic        sp_v, stall, irq;
	logic [3:0]  adr, sel, lane;
	logic [31:0] wdat, rdat;
	logic [15:0] ptr, bword;
	logic [7:0]  dlo, dhi, sp_rd, q;
	logic [4:0]  bidx;
	flash_cmd_t  cmd;
	int          errors, checks;

	flash_self_program_sequencer u_flash_self_program_sequencer (
		.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .store_instr_in(store), .load_instr_in(load),
		.pointer_in(ptr), .data_low_reg_in(dlo), .data_high_reg_in(dhi),
		.lock_bits_in(8'h3c), .fuse_bits_in(8'hd2), .flash_done_in(done),
		.buf_index_in(bidx), .buf_word_out(bword), .flash_cmd_out(cmd),
		.special_read_out(sp_rd), .special_valid_out(sp_v),
		.cpu_stall_out(stall), .ready_irq_out(irq));

	flash_array_model u_flash_array_model (.clk_in(clk_in),
		.rstn_in(rstn_in), .cmd_in(cmd), .delay_in(4'ha), .done_out(done));

	// ****************************************
	// Shared bus and compare tasks
	// ****************************************

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; returns at the edge where ack was sampled.
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_in);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		sel  <= lane;
		adr  <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1);
		chk(n, 32'h2);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask

	// Reads a register and compares it.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	// Store pulse, taken at the edge after the one it is called at.
	task automatic st(input logic [15:0] p, input logic [7:0] l, h);
		ptr <= p; dlo <= l; dhi <= h; store <= 1'b1;
		@(posedge clk_in);
		store <= 1'b0;
	endtask

	// Waits a bounded time for start (0), done (1) or read valid (2).
	task automatic wait_hi(input int s);
		int   n;
		logic f;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
			f = s == 0 ? cmd.start : s == 1 ? done : sp_v;
		end while (f !== 1'b1 && n < 40);
		chk(f, 1'b1);
	endtask

	// Reads one word of the page buffer.
	task automatic buf_chk(input logic [4:0] i, input logic [15:0] exp);
		@(posedge clk_in); bidx <= i;
		repeat (2) @(posedge clk_in);
		chk(bword, exp);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************

	// Reset values, unmapped place, refused pattern, ready request.
	task automatic t_regs;
		rd(4'h0, 8'h00);
		chk(irq, 1'b0);
		wb(1'b1, 4'h5, 8'hff); rd(4'h5, 8'h00);
		lane = 4'h2;
		wb(1'b1, 4'h0, 8'h81);
		lane = 4'h1;
		rd(4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h87); rd(4'h0, 8'h80);
		repeat (2) @(posedge clk_in);
		chk(irq, 1'b1);
		wb(1'b1, 4'h0, 8'h00);
		$display("test regs done");
	endtask

	// Word loads in any order, second load ignored, enable clears.
	task automatic t_load;
		wb(1'b1, 4'h0, 8'h01); st(16'h0006, 8'h34, 8'h12);
		rd(4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h01); st(16'h0007, 8'h78, 8'h56);
		wb(1'b1, 4'h0, 8'h01); st(16'h0002, 8'hbc, 8'h9a);
		@(posedge clk_in);
		st(16'h0004, 8'h11, 8'h11);
		buf_chk(5'h03, 16'h1234);
		buf_chk(5'h01, 16'h9abc);
		buf_chk(5'h02, 16'hffff);
		$display("test load done");
	endtask

	// Erase and then write of one readable-section page, core not stalled.
	task automatic t_erase_write;
		wb(1'b1, 4'h0, 8'h03); st(16'h007f, 8'h00, 8'h00);
		ptr <= 16'hffff;
		wait_hi(0);
		chk({cmd.erase, cmd.write}, 2'b10);
		chk(cmd.page, 16'h0001);
		chk(stall, 1'b0);
		rd(4'h0, 8'h43);
		wait_hi(1);
		rd(4'h0, 8'h40);
		wb(1'b1, 4'h0, 8'h05); st(16'h005e, 8'h00, 8'h00);
		wait_hi(0);
		chk({cmd.erase, cmd.write}, 2'b01);
		chk(cmd.page, 16'h0001);
		rd(4'h0, 8'h45);
		chk(stall, 1'b0);
		wait_hi(1);
		rd(4'h0, 8'h40);
		chk(stall, 1'b0);
		buf_chk(5'h03, 16'hffff);
		$display("test erase_write done");
	endtask

	// Stalling page: erase, fill, write; then a window that runs out.
	task automatic t_stall_timeout;
		wb(1'b1, 4'h0, 8'h03); st(16'hfc00, 8'h00, 8'h00);
		wait_hi(0);
		rd(4'h0, 8'h43);
		chk(stall, 1'b1);
		wait_hi(1);
		rd(4'h0, 8'h40); chk(stall, 1'b0);
		wb(1'b1, 4'h0, 8'h01); st(16'hfc02, 8'hcd, 8'hab);
		buf_chk(5'h01, 16'habcd);
		wb(1'b1, 4'h0, 8'h05); st(16'hfc00, 8'h00, 8'h00);
		wait_hi(0);
		chk({cmd.write, cmd.page}, {1'b1, 16'h03f0});
		rd(4'h0, 8'h05);
		chk(stall, 1'b1);
		wait_hi(1);
		rd(4'h0, 8'h00); chk(stall, 1'b0);
		wb(1'b1, 4'h0, 8'h03);
		repeat (3) @(posedge clk_in);
		st(16'h0040, 8'h00, 8'h00);
		repeat (3) begin @(posedge clk_in); chk(cmd.start, 1'b0); end
		rd(4'h0, 8'h00);
		$display("test stall_timeout done");
	endtask

	// Lock and fuse reads, lock programming, lock window timeout.
	task automatic t_lock;
		for (int z = 0; z < 2; z++) begin
			wb(1'b1, 4'h0, 8'h09);
			ptr <= 16'(z); load <= 1'b1;
			@(posedge clk_in);
			load <= 1'b0;
			wait_hi(2);
			chk(sp_rd, z ? 8'hd2 : 8'h3c);
			repeat (4) @(posedge clk_in);
			rd(4'h0, 8'h00);
		end
		wb(1'b1, 4'h0, 8'h09); st(16'hffff, 8'ha5, 8'h5a);
		wait_hi(0);
		chk({cmd.lock, cmd.lock_data, cmd.page}, {1'b1, 24'ha50000});
		wait_hi(1);
		rd(4'h0, 8'h00);
		$display("test lock done");
	endtask

	// Re-enable clears the buffer and the busy flag.
	task automatic t_reenable;
		wb(1'b1, 4'h0, 8'h01); st(16'h0010, 8'h22, 8'h33);
		wb(1'b1, 4'h0, 8'h03); st(16'h0040, 8'h00, 8'h00);
		wait_hi(1);
		rd(4'h0, 8'h40);
		buf_chk(5'h08, 16'h3322);
		wb(1'b1, 4'h0, 8'h11); st(16'h0000, 8'h00, 8'h00);
		rd(4'h0, 8'h00);
		buf_chk(5'h08, 16'hffff);
		$display("test reenable done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Clock at 200 MHz.
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Cuts a hang short well after the tests should have ended.
	initial begin
		repeat (5000) @(posedge clk_in);
		errors++;
		give_verdict();
	end

	// Main sequence: reset, then each scenario in turn.
	initial begin
		errors = 0; checks = 0; rstn_in = 1'b0; cyc = 1'b0; stb = 1'b0;
		we = 1'b0; adr = 4'h0; wdat = 32'h0; store = 1'b0; load = 1'b0;
		ptr = 16'h0; dlo = 8'h0; dhi = 8'h0; bidx = 5'h0;
		sel = 4'h0;
		lane = 4'h1;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_regs();
		t_load();
		t_erase_write();
		t_stall_timeout();
		t_lock();
		t_reenable();
		give_verdict();
	end
endmodule // flash_self_program_sequencer_tb

// [verilog/flash_self_program_sequencer.sv]
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Lock arm plus enable: next store in four cycles programs locks from low data.
// - Lock arm clears after lock programming or after four idle cycles.
// - Load within three cycles after lock arm returns lock or fuse bits.
// - Write arm plus enable: next store writes buffer to the pointer page.
// - Write arm clears when the page write ends or the window expires.
// - Core stalls during a page write to the stalling section.
// - Erase arm plus enable: next store erases the pointer page.
// - Erase arm clears when the erase ends or the window expires.
// - Enable alone: one store loads data into the addressed buffer word.
// - Enable clears after a store or timeout; held during erase and write.
// - Only five patterns of the lower five bits take effect.
// - Target page and lock data are captured when an operation starts.
// - Low pointer bits select the word, high bits select the page.
// - Buffer words load in any order.
// - Buffer load uses the word field of the pointer.
// - Buffer clears after page write, on re-enable arm, and on reset.
// - A buffer word loads once between clears.
// - Erase of the readable section leaves the core running.
// - Erase of the stalling section stalls the core until done.
// - Busy flag set on readable-section work, cleared by re-enable or load.
// - Ready request is a level while enabled and the enable bit is clear.
module flash_self_program_sequencer #(
	parameter int WORD_BITS = 5,
	parameter int RWW_PAGES = 384
) (
	input  wire logic                        clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        wb_cyc_in,
	input  wire logic                        wb_stb_in,
	input  wire logic                        wb_we_in,
	input  wire logic [3:0]                  wb_adr_in,
	input  wire logic [3:0]                  wb_sel_in,
	input  wire logic [31:0]                 wb_dat_in,
	output logic      [31:0]                 wb_dat_out,
	output logic                             wb_ack_out,
	input  wire logic                        store_instr_in,
	input  wire logic                        load_instr_in,
	input  wire logic [15:0]                 pointer_in,
	input  wire logic [7:0]                  data_low_reg_in,
	input  wire logic [7:0]                  data_high_reg_in,
	input  wire logic [7:0]                  lock_bits_in,
	input  wire logic [7:0]                  fuse_bits_in,
	input  wire logic                        flash_done_in,
	input  wire logic [WORD_BITS-1:0]        buf_index_in,
	output logic      [15:0]                 buf_word_out,
	output flash_seq_pkg::flash_cmd_t        flash_cmd_out,
	output logic      [7:0]                  special_read_out,
	output logic                             special_valid_out,
	output logic                             cpu_stall_out,
	output logic                             ready_irq_out
);
	import flash_seq_pkg::*;

	localparam int WORDS = 1 << WORD_BITS;

	// Refuse word fields that leave no page bits in the pointer.
	if (WORD_BITS < 1 || WORD_BITS > 14 ||
		RWW_PAGES < 1) begin : g_bad_params
		$error("flash_self_program_sequencer: bad parameters");
	end

	// ****************************************
	// State
	// ****************************************

	logic              ctrl_en;
	logic              ctrl_ers;
	logic              ctrl_wrt;
	logic              ctrl_lock;
	logic              ctrl_reen;
	logic              ctrl_irq_en;
	logic              busy;
	logic [2:0]        age;
	op_state_t         state;
	op_state_t         next_state;
	logic [15:0]       buf_mem [WORDS];
	logic [WORDS-1:0]  buf_full;

	// Tells whether a five-bit control pattern is one the block accepts.
	function automatic logic pattern_ok(input logic [4:0] p);
		return p == PAT_REEN || p == PAT_LOCK || p == PAT_WRITE ||
			p == PAT_ERASE || p == PAT_LOAD;
	endfunction

	// Page index held in the upper pointer bits.
	function automatic logic [15:0] page_of(input logic [15:0] z);
		return z >> (WORD_BITS + 1);
	endfunction

	// Word within the page, skipping the byte select bit.
	function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
		return z[WORD_BITS:1];
	endfunction

	// ****************************************
	// Command decode
	// ****************************************

	logic idle;
	logic bus_req;
	logic ctrl_write;
	logic accept_pat;
	logic armed;
	logic store_ok;
	logic load_only;
	logic reen_only;
	logic op_done;
	logic stall_page;
	logic [WORD_BITS-1:0] word_idx;

	// An arming pattern is taken only while no operation runs.
	assign idle       = state == ST_IDLE;
	assign bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign ctrl_write = bus_req && wb_we_in && wb_sel_in[0] &&
		wb_adr_in == ADDR_CONTROL;
	assign accept_pat = ctrl_write && idle && pattern_ok(wb_dat_in[4:0]);
	assign armed      = ctrl_en && idle && age < STORE_WINDOW;
	assign store_ok   = store_instr_in && armed;
	assign load_only  = !(ctrl_ers || ctrl_wrt || ctrl_lock || ctrl_reen);
	assign reen_only  = ctrl_reen;
	assign op_done    = !idle && flash_done_in;
	assign stall_page = page_of(pointer_in) >= 16'(RWW_PAGES);
	assign word_idx   = word_of(pointer_in);

	// ****************************************
	// Wishbone slave
	// ****************************************

	// Every access is answered one cycle after it is presented.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
		end else begin
			wb_ack_out <= bus_req;
			if (bus_req && !wb_we_in && wb_adr_in == ADDR_CONTROL)
				wb_dat_out <= {24'h0, ctrl_irq_en, busy, 1'b0, ctrl_reen,
					ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en};
			else
				wb_dat_out <= 32'h0;
		end
	end

	// ****************************************
	// Control bits and arming window
	// ****************************************

	// Arms a command, ages the window, clears on use, timeout or finish.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{ctrl_reen, ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en} <= CTRL_RESET[4:0];
			age <= 3'h0;
		end else if (accept_pat) begin
			{ctrl_reen, ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en} <= wb_dat_in[4:0];
			age <= 3'h0;
		end else if (op_done) begin
			{ctrl_reen, ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en} <= 5'h00;
		end else if (store_ok && (load_only || reen_only)) begin
			{ctrl_reen, ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en} <= 5'h00;
		end else if (ctrl_en && idle && !store_ok) begin
			if (age >= STORE_WINDOW - 3'h1)
				{ctrl_reen, ctrl_lock, ctrl_wrt, ctrl_ers, ctrl_en} <= 5'h00;
			else
				age <= age + 3'h1;
		end
	end

	// Interrupt enable is writable at any time.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			ctrl_irq_en <= CTRL_RESET[BIT_IRQ_EN];
		else if (ctrl_write)
			ctrl_irq_en <= wb_dat_in[BIT_IRQ_EN];
	end

	// ****************************************
	// Operation sequencer
	// ****************************************

	// Picks the operation started by an accepted store.
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (store_ok && ctrl_ers)
					next_state = ST_ERASE;
				else if (store_ok && ctrl_wrt)
					next_state = ST_WRITE;
				else if (store_ok && ctrl_lock)
					next_state = ST_LOCK;
			end
			ST_ERASE, ST_WRITE, ST_LOCK: begin
				if (flash_done_in)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Issues the flash command and latches its target at the start.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flash_cmd_out <= '0;
		end else if (idle && next_state != ST_IDLE) begin
			flash_cmd_out.start     <= 1'b1;
			flash_cmd_out.erase     <= next_state == ST_ERASE;
			flash_cmd_out.write     <= next_state == ST_WRITE;
			flash_cmd_out.lock      <= next_state == ST_LOCK;
			flash_cmd_out.page      <= ctrl_lock ? 16'h0 : page_of(pointer_in);
			flash_cmd_out.lock_data <= data_low_reg_in;
		end else begin
			flash_cmd_out.start <= 1'b0;
		end
	end

	// Halts the core while the stalling section is erased or written.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			cpu_stall_out <= 1'b0;
		else if (idle && (next_state == ST_ERASE || next_state == ST_WRITE))
			cpu_stall_out <= stall_page;
		else if (op_done)
			cpu_stall_out <= 1'b0;
	end

	// Marks the readable section busy until re-enabled or a load begins.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			busy <= 1'b0;
		else if (idle && (next_state == ST_ERASE || next_state == ST_WRITE) &&
			!stall_page)
			busy <= 1'b1;
		else if (store_ok && (load_only || reen_only))
			busy <= 1'b0;
	end

	// ****************************************
	// Temporary page buffer
	// ****************************************

	// Loads each word once; clears after a write or a re-enable arm.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			buf_full <= '0;
			for (int i = 0; i < WORDS; i++)
				buf_mem[i] <= 16'hffff;
		end else if ((state == ST_WRITE && flash_done_in) ||
			(accept_pat && wb_dat_in[4:0] == PAT_REEN)) begin
			buf_full <= '0;
			for (int i = 0; i < WORDS; i++)
				buf_mem[i] <= 16'hffff;
		end else if (store_ok && load_only && !buf_full[word_idx]) begin
			buf_mem[word_idx]  <= {data_high_reg_in, data_low_reg_in};
			buf_full[word_idx] <= 1'b1;
		end
	end

	// Read port for the flash array during a page write.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			buf_word_out <= 16'h0;
		else
			buf_word_out <= buf_mem[buf_index_in];
	end

	// ****************************************
	// Lock and fuse read, ready request
	// ****************************************

	// Returns lock or fuse bits to a load shortly after a lock arm.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			special_read_out  <= 8'h0;
			special_valid_out <= 1'b0;
		end else if (load_instr_in && ctrl_en && ctrl_lock && idle &&
			age < READ_WINDOW) begin
			special_read_out  <= pointer_in[0] ? fuse_bits_in : lock_bits_in;
			special_valid_out <= 1'b1;
		end else begin
			special_valid_out <= 1'b0;
		end
	end

	// Level request while enabled and no command is pending.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			ready_irq_out <= 1'b0;
		else
			ready_irq_out <= ctrl_irq_en && !ctrl_en;
	end

	// ****************************************
	// Assertions
	// ****************************************

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_erase_start: assert property (
		store_ok && ctrl_ers |=> state == ST_ERASE && flash_cmd_out.start &&
			flash_cmd_out.erase)
		else $error("accepted erase store did not start an erase");

	a_window_expiry: assert property (
		$rose(ctrl_en) && idle && !store_instr_in && !accept_pat ##1
			(!store_instr_in && idle && !accept_pat) [*3] |=> !ctrl_en)
		else $error("enable bit outlived its four cycle window");

	a_enable_held: assert property (
		(state == ST_ERASE || state == ST_WRITE) && !flash_done_in |=> ctrl_en)
		else $error("enable bit dropped during erase or write");

	a_buffer_once: assert property (
		store_ok && load_only && buf_full[word_idx] && !accept_pat |=>
			buf_mem[$past(word_idx)] == $past(buf_mem[word_idx]))
		else $error("loaded buffer word was overwritten");

	a_bad_pattern: assert property (
		ctrl_write && !pattern_ok(wb_dat_in[4:0]) && !op_done && !ctrl_en |=>
			!ctrl_en && !ctrl_ers && !ctrl_wrt)
		else $error("illegal pattern changed the control bits");

	a_disabled_store: assert property (
		store_instr_in && !ctrl_en |=> idle && !flash_cmd_out.start)
		else $error("store without enable started an operation");

	a_stall_section: assert property (
		cpu_stall_out && !flash_done_in |=> cpu_stall_out)
		else $error("core stall released before the operation ended");

	a_busy_rises: assert property (
		idle && store_ok && (ctrl_ers || ctrl_wrt) && !stall_page |=>
			busy && !cpu_stall_out)
		else $error("readable section work did not set busy");

	a_page_latched: assert property (
		!idle && !flash_cmd_out.start |-> $stable(flash_cmd_out.page))
		else $error("target page moved during an operation");

	a_read_window: assert property (
		load_instr_in && ctrl_en && ctrl_lock && idle && age < READ_WINDOW |=>
			special_valid_out)
		else $error("lock or fuse read was not answered");

	a_ready_level: assert property (
		ctrl_irq_en && !ctrl_en ##1 ctrl_irq_en && !ctrl_en |-> ready_irq_out)
		else $error("ready request missing while enable is clear");

endmodule // flash_self_program_sequencer
